// >>> verilog/dual_port_ram_core.sv
// Behaviour
// - Width code picks 4kx1, 2kx2, 1kx4, 512x9
// - Width codes never change while operating
// - Select low enables port; high holds output
// - Write enable low writes, high reads
// - Each port acts on its own clock
// - Unregistered read shows data same cycle
// - Registered read shows data one cycle later
// - Write without passthrough keeps last read data
// - Write with passthrough shows written data
// - Passthrough ignored on reads
// - Reset clears holds, blocks reads and writes
// - Reset leaves array contents intact
// - Reset kept away from active port edges
// - Twelve-bit location for reads and writes
// - Unused upper location bits held zero
// - Unused port has inputs and clock low
// - Port B clock inverted from port A
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"

module dual_port_ram_core (
  input wire logic clock,
  input wire logic sys_rst,
  ram_link_if.ram_end link
);
  import ram_pkg::*;

  localparam int WORDS = `RAM_WORDS;

  logic [1:0] edge_in;
  logic [1:0] sel_n;
  logic [1:0] wr_n;
  logic [1:0] pipe;
  logic [1:0] pass;
  logic [1:0][1:0] wsel;
  logic [1:0][`RAM_ADDR_W-1:0] loc;
  logic [1:0][`RAM_DATA_W-1:0] wdat;

  logic [1:0] wr_en;
  logic [1:0][`RAM_WORD_W-1:0] wr_word;
  logic [1:0][`RAM_DATA_W-1:0] wr_mask;
  logic [1:0][`RAM_DATA_W-1:0] wr_bits;

  core_state_t st_r;
  core_state_t st_nxt;

  // No reset on purpose: contents survive both resets
  logic [`RAM_DATA_W-1:0] mem [0:WORDS-1];

  // Port clocks arrive as one-cycle edge strobes on the system clock
  assign edge_in = {link.port_b_clock, link.port_a_clock};
  assign sel_n = {link.port_b_select_n, link.port_a_select_n};
  assign wr_n = {link.port_b_write_n, link.port_a_write_n};
  assign pipe = {link.port_b_registered_read,
                 link.port_a_registered_read};
  assign pass = {link.port_b_write_passthrough,
                 link.port_a_write_passthrough};
  assign wsel = {link.port_b_width_select, link.port_a_width_select};
  assign loc = {link.port_b_location, link.port_a_location};
  assign wdat = {link.port_b_write_data, link.port_a_write_data};

  // Word index inside the 512x9 array for a given organisation
  function automatic logic [`RAM_WORD_W-1:0] word_of(
    input logic [1:0] w,
    input logic [`RAM_ADDR_W-1:0] a
  );
    case (w)
      ORG_4KX1: word_of = a[11:3];
      ORG_2KX2: word_of = a[10:2];
      ORG_1KX4: word_of = a[9:1];
      ORG_512X9: word_of = a[8:0];
      default: word_of = a[8:0];
    endcase
  endfunction : word_of

  // Bit lane selected within the word
  function automatic logic [`RAM_DATA_W-1:0] lane_mask(
    input logic [1:0] w,
    input logic [`RAM_ADDR_W-1:0] a
  );
    case (w)
      ORG_4KX1: lane_mask = `RAM_LANE_X1 << a[2:0];
      ORG_2KX2: lane_mask = `RAM_LANE_X2 << {a[1:0], 1'b0};
      ORG_1KX4: lane_mask = `RAM_LANE_X4 << {a[0], 2'h0};
      ORG_512X9: lane_mask = `RAM_LANE_X9;
      default: lane_mask = `RAM_LANE_X9;
    endcase
  endfunction : lane_mask

  // Position of the lane's lowest bit
  function automatic logic [`RAM_SHIFT_W-1:0] lane_shift(
    input logic [1:0] w,
    input logic [`RAM_ADDR_W-1:0] a
  );
    case (w)
      ORG_4KX1: lane_shift = {1'b0, a[2:0]};
      ORG_2KX2: lane_shift = {1'b0, a[1:0], 1'b0};
      ORG_1KX4: lane_shift = {1'b0, a[0], 2'h0};
      ORG_512X9: lane_shift = 4'h0;
      default: lane_shift = 4'h0;
    endcase
  endfunction : lane_shift

  always_comb begin
    logic acc;
    logic upd;
    logic [`RAM_SHIFT_W-1:0] sh;
    logic [`RAM_DATA_W-1:0] rd;
    logic [`RAM_DATA_W-1:0] val;
    acc = 1'b0;
    upd = 1'b0;
    sh = '0;
    rd = '0;
    val = '0;
    st_nxt = st_r;
    wr_en = '0;
    wr_word = '0;
    wr_mask = '0;
    wr_bits = '0;
    // Same code for both ports; nothing crosses between them
    for (int p = 0; p < 2; p++) begin
      // Access only on own edge, select low, reset released
      acc = edge_in[p] && !sel_n[p] && link.ram_reset_n;
      sh = lane_shift(wsel[p], loc[p]);
      wr_word[p] = word_of(wsel[p], loc[p]);
      wr_mask[p] = lane_mask(wsel[p], loc[p]);
      wr_bits[p] = (wdat[p] << sh) & wr_mask[p];
      wr_en[p] = acc && !wr_n[p];
      rd = (mem[wr_word[p]] & wr_mask[p]) >> sh;
      // A write without passthrough leaves the stage and the unregistered output alone
      upd = acc && (wr_n[p] || pass[p]);
      // Reads always return array data, whatever passthrough says
      if (wr_n[p]) begin
        val = rd;
      end else begin
        val = wdat[p] & (wr_mask[p] >> sh);
      end
      if (pipe[p]) begin
        // Stage feeds the output on the port's next edge
        if (acc) begin
          st_nxt.port[p].dout = st_r.port[p].stage;
          if (upd) begin
            st_nxt.port[p].stage = val;
          end
        end
      end else if (upd) begin
        st_nxt.port[p].dout = val;
      end
    end
    if (sys_rst || !link.ram_reset_n) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  // Both ports may hit one word; separate bit writes keep both lanes
  always_ff @(posedge clock) begin
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < `RAM_DATA_W; i++) begin
        if (wr_en[p] && wr_mask[p][i]) begin
          mem[wr_word[p]][i] <= wr_bits[p][i];
        end
      end
    end
  end

  assign link.port_a_read_data = st_r.port[0].dout;
  assign link.port_b_read_data = st_r.port[1].dout;

endmodule : dual_port_ram_core

`default_nettype wire

// >>> verilog/ram_params.svh
`ifndef RAM_PARAMS_SVH
`define RAM_PARAMS_SVH

`define RAM_ADDR_W 12
`define RAM_DATA_W 9
`define RAM_WORDS 512
`define RAM_WORD_W 9
`define RAM_SHIFT_W 4
`define RAM_CNT_W 4
`define RAM_DIV 4
`define RAM_RST_SLOT 4'h1

`define RAM_ORG_4KX1 2'h0
`define RAM_ORG_2KX2 2'h1
`define RAM_ORG_1KX4 2'h2
`define RAM_ORG_512X9 2'h3

`define RAM_LOC_MASK_4K 12'hFFF
`define RAM_LOC_MASK_2K 12'h7FF
`define RAM_LOC_MASK_1K 12'h3FF
`define RAM_LOC_MASK_512 12'h1FF

`define RAM_LANE_X1 9'h001
`define RAM_LANE_X2 9'h003
`define RAM_LANE_X4 9'h00F
`define RAM_LANE_X9 9'h1FF

`endif

// >>> verilog/ram_pkg.sv
`default_nettype none
`include "ram_params.svh"

package ram_pkg;

  typedef enum logic [1:0] {
    ORG_4KX1 = `RAM_ORG_4KX1,
    ORG_2KX2 = `RAM_ORG_2KX2,
    ORG_1KX4 = `RAM_ORG_1KX4,
    ORG_512X9 = `RAM_ORG_512X9
  } org_t;

  typedef struct packed {
    logic [`RAM_DATA_W-1:0] dout;
    logic [`RAM_DATA_W-1:0] stage;
  } out_hold_t;

  typedef struct packed {
    out_hold_t [1:0] port;
  } core_state_t;

  typedef struct packed {
    logic idle;
    logic wr;
    logic [`RAM_ADDR_W-1:0] loc;
    logic [`RAM_DATA_W-1:0] wdat;
    logic clk;
    logic sel_n;
    logic wr_n;
    logic pipe;
    logic pass;
    logic [1:0] width;
    logic [`RAM_ADDR_W-1:0] l_loc;
    logic [`RAM_DATA_W-1:0] l_wdat;
    logic [1:0] back;
    logic [`RAM_DATA_W-1:0] rdata;
    logic rvalid;
  } user_port_t;

  typedef struct packed {
    logic [`RAM_CNT_W-1:0] cnt;
    org_t width;
    logic ram_rst_n;
    user_port_t [1:0] port;
  } user_state_t;

endpackage : ram_pkg

`default_nettype wire

// >>> verilog/ram_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"

interface ram_link_if;
  logic ram_reset_n;
  logic port_a_clock;
  logic port_a_select_n;
  logic port_a_write_n;
  logic port_a_registered_read;
  logic port_a_write_passthrough;
  logic [1:0] port_a_width_select;
  logic [`RAM_ADDR_W-1:0] port_a_location;
  logic [`RAM_DATA_W-1:0] port_a_write_data;
  logic [`RAM_DATA_W-1:0] port_a_read_data;
  logic port_b_clock;
  logic port_b_select_n;
  logic port_b_write_n;
  logic port_b_registered_read;
  logic port_b_write_passthrough;
  logic [1:0] port_b_width_select;
  logic [`RAM_ADDR_W-1:0] port_b_location;
  logic [`RAM_DATA_W-1:0] port_b_write_data;
  logic [`RAM_DATA_W-1:0] port_b_read_data;

  modport ram_end (
    input ram_reset_n,
    input port_a_clock, port_a_select_n, port_a_write_n,
    input port_a_registered_read, port_a_write_passthrough,
    input port_a_width_select, port_a_location, port_a_write_data,
    output port_a_read_data,
    input port_b_clock, port_b_select_n, port_b_write_n,
    input port_b_registered_read, port_b_write_passthrough,
    input port_b_width_select, port_b_location, port_b_write_data,
    output port_b_read_data
  );

  modport user_end (
    output ram_reset_n,
    output port_a_clock, port_a_select_n, port_a_write_n,
    output port_a_registered_read, port_a_write_passthrough,
    output port_a_width_select, port_a_location, port_a_write_data,
    input port_a_read_data,
    output port_b_clock, port_b_select_n, port_b_write_n,
    output port_b_registered_read, port_b_write_passthrough,
    output port_b_width_select, port_b_location, port_b_write_data,
    input port_b_read_data
  );
endinterface : ram_link_if

`default_nettype wire

// >>> verilog/dual_port_ram_user.sv
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"

module dual_port_ram_user #(
  parameter int DIV = `RAM_DIV
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] width_cfg,
  input wire logic [1:0] port_enable,
  input wire logic [1:0] registered_read,
  input wire logic [1:0] write_passthrough,
  input wire logic ram_reset_req,
  input wire logic [1:0] req,
  input wire logic [1:0] write,
  input wire logic [1:0][`RAM_ADDR_W-1:0] location,
  input wire logic [1:0][`RAM_DATA_W-1:0] write_data,
  output logic [1:0] ready,
  output logic [1:0][`RAM_DATA_W-1:0] read_data,
  output logic [1:0] read_valid,
  ram_link_if.user_end link
);
  import ram_pkg::*;

  user_state_t st_r;
  user_state_t st_nxt;
  logic [1:0][`RAM_DATA_W-1:0] link_rd;

  assign link_rd = {link.port_b_read_data, link.port_a_read_data};

  // Upper location bits beyond the configured depth forced to zero
  function automatic logic [`RAM_ADDR_W-1:0] loc_mask(input org_t w);
    case (w)
      ORG_4KX1: loc_mask = `RAM_LOC_MASK_4K;
      ORG_2KX2: loc_mask = `RAM_LOC_MASK_2K;
      ORG_1KX4: loc_mask = `RAM_LOC_MASK_1K;
      ORG_512X9: loc_mask = `RAM_LOC_MASK_512;
      default: loc_mask = `RAM_LOC_MASK_512;
    endcase
  endfunction : loc_mask

  always_comb begin
    logic tick;
    logic [`RAM_ADDR_W-1:0] lm;
    tick = 1'b0;
    lm = loc_mask(st_r.width);
    st_nxt = st_r;
    st_nxt.cnt = (st_r.cnt == `RAM_CNT_W'(DIV - 1)) ?
                 '0 : st_r.cnt + `RAM_CNT_W'(1);
    // Reset moves only in a slot clear of both port edges
    if (st_r.cnt == `RAM_RST_SLOT) begin
      st_nxt.ram_rst_n = !ram_reset_req;
    end
    for (int p = 0; p < 2; p++) begin
      // B strobes half a divider period after A: inverted clock
      tick = (st_r.cnt == ((p == 0) ? '0 : `RAM_CNT_W'(DIV / 2)));
      st_nxt.port[p].clk = tick && port_enable[p];
      st_nxt.port[p].sel_n = 1'b1;
      st_nxt.port[p].pipe = registered_read[p];
      st_nxt.port[p].pass = write_passthrough[p];
      st_nxt.port[p].width = st_r.width;
      st_nxt.port[p].back = {st_r.port[p].back[0], 1'b0};
      st_nxt.port[p].rvalid = st_r.port[p].back[1];
      if (st_r.port[p].back[1]) begin
        st_nxt.port[p].rdata = link_rd[p];
      end
      if (req[p] && st_r.port[p].idle) begin
        st_nxt.port[p].idle = 1'b0;
        st_nxt.port[p].wr = write[p];
        st_nxt.port[p].loc = location[p] & lm;
        st_nxt.port[p].wdat = write_data[p];
      end
      // Requests wait out a held memory reset
      if (tick && !st_r.port[p].idle && st_r.ram_rst_n) begin
        st_nxt.port[p].sel_n = 1'b0;
        st_nxt.port[p].wr_n = !st_r.port[p].wr;
        st_nxt.port[p].l_loc = st_r.port[p].loc;
        st_nxt.port[p].l_wdat = st_r.port[p].wdat;
        st_nxt.port[p].idle = 1'b1;
        st_nxt.port[p].back[0] = !st_r.port[p].wr;
      end
      // Unused port: every input and its clock tied low
      if (!port_enable[p]) begin
        st_nxt.port[p] = '0;
      end
    end
    if (sys_rst) begin
      st_nxt = '0;
      // Organisation caught once, while reset is held
      st_nxt.width = org_t'(width_cfg);
      for (int p = 0; p < 2; p++) begin
        st_nxt.port[p].idle = port_enable[p];
        st_nxt.port[p].sel_n = port_enable[p];
        st_nxt.port[p].wr_n = port_enable[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  assign ready = {st_r.port[1].idle, st_r.port[0].idle};
  assign read_data = {st_r.port[1].rdata, st_r.port[0].rdata};
  assign read_valid = {st_r.port[1].rvalid, st_r.port[0].rvalid};

  assign link.ram_reset_n = st_r.ram_rst_n;
  assign link.port_a_clock = st_r.port[0].clk;
  assign link.port_a_select_n = st_r.port[0].sel_n;
  assign link.port_a_write_n = st_r.port[0].wr_n;
  assign link.port_a_registered_read = st_r.port[0].pipe;
  assign link.port_a_write_passthrough = st_r.port[0].pass;
  assign link.port_a_width_select = st_r.port[0].width;
  assign link.port_a_location = st_r.port[0].l_loc;
  assign link.port_a_write_data = st_r.port[0].l_wdat;
  assign link.port_b_clock = st_r.port[1].clk;
  assign link.port_b_select_n = st_r.port[1].sel_n;
  assign link.port_b_write_n = st_r.port[1].wr_n;
  assign link.port_b_registered_read = st_r.port[1].pipe;
  assign link.port_b_write_passthrough = st_r.port[1].pass;
  assign link.port_b_width_select = st_r.port[1].width;
  assign link.port_b_location = st_r.port[1].l_loc;
  assign link.port_b_write_data = st_r.port[1].l_wdat;

endmodule : dual_port_ram_user

`default_nettype wire

// >>> verification/dual_port_block_ram_ports_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"

module dual_port_block_ram_ports_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ram_reset_n,
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_write_n,
  input wire logic port_a_registered_read,
  input wire logic port_a_write_passthrough,
  input wire logic [1:0] port_a_width_select,
  input wire logic [`RAM_ADDR_W-1:0] port_a_location,
  input wire logic [`RAM_DATA_W-1:0] port_a_write_data,
  input wire logic [`RAM_DATA_W-1:0] port_a_read_data,
  input wire logic port_b_clock,
  input wire logic port_b_select_n,
  input wire logic [1:0] port_b_width_select,
  input wire logic [`RAM_DATA_W-1:0] port_b_read_data
);
  logic take_a;
  logic take_b;
  assign take_a = port_a_clock && !port_a_select_n && ram_reset_n;
  assign take_b = port_b_clock && !port_b_select_n && ram_reset_n;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Plain write: no passthrough, unregistered, so the output must not move
  sequence s_keep_a;
    take_a && !port_a_write_n && !port_a_write_passthrough &&
      !port_a_registered_read;
  endsequence
  // Passthrough only checked at full width, narrower widths mask lanes
  sequence s_pass_a;
    take_a && !port_a_write_n && port_a_write_passthrough &&
      !port_a_registered_read && port_a_width_select == 2'h3;
  endsequence

  a_idle_hold_a: assert property (ram_reset_n && !take_a |=>
    $stable(port_a_read_data)) else $error("port a output moved while idle");
  a_idle_hold_b: assert property (ram_reset_n && !take_b |=>
    $stable(port_b_read_data)) else $error("port b output moved while idle");
  a_mem_reset_zero: assert property (!ram_reset_n |=>
    port_a_read_data == '0 && port_b_read_data == '0)
    else $error("outputs not cleared by memory reset");
  a_plain_write_keeps: assert property (s_keep_a |=>
    $stable(port_a_read_data)) else $error("plain write changed output");
  a_passthrough_shows: assert property (s_pass_a |=>
    port_a_read_data == $past(port_a_write_data))
    else $error("passthrough data not on output");
  a_strobe_single: assert property (port_a_clock |=> !port_a_clock)
    else $error("port a strobe longer than one cycle");
  a_strobes_apart: assert property (port_a_clock |-> !port_b_clock)
    else $error("port strobes coincide");
  a_width_match: assert property (
    port_a_width_select == port_b_width_select)
    else $error("port width codes differ");
  a_width_fixed: assert property (
    ram_reset_n && $past(ram_reset_n) |-> $stable(port_a_width_select))
    else $error("width code changed in run");
  // Core ignores upper bits at full width, so only the link shows this
  a_loc_upper_zero: assert property (take_a |->
    !(port_a_width_select == 2'h3 && port_a_location[11:9] != 3'h0) &&
    !(port_a_width_select == 2'h2 && port_a_location[11:10] != 2'h0) &&
    !(port_a_width_select == 2'h1 && port_a_location[11]))
    else $error("upper location bits not zero");
  // Divider of 4: port b ticks two cycles after port a while b is in use
  a_b_half_later: assert property (
    port_a_clock && port_b_select_n |-> ##2 port_b_clock)
    else $error("port b strobe not half a period after port a");
endmodule : dual_port_block_ram_ports_props

`default_nettype wire

// >>> verification/dual_port_block_ram_ports_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ram_params.svh"

`define CHK(name, exp, got) begin total_checks++; if ((got) !== (exp)) \
  begin miscompares++; \
  $display("mismatch %s expected %h seen %h", name, exp, got); end end

module dual_port_block_ram_ports_test;
  typedef struct packed {
    logic p;
    logic wr;
    logic [`RAM_ADDR_W-1:0] loc;
    logic [`RAM_DATA_W-1:0] wd;
    logic [`RAM_DATA_W-1:0] exp;
  } row_t;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] width_cfg = 2'h3;
  logic [1:0] port_enable = 2'h3;
  logic [1:0] registered_read = 2'h0;
  logic [1:0] write_passthrough = 2'h0;
  logic ram_reset_req = 1'b0;
  logic [1:0] req = 2'h0;
  logic [1:0] write = 2'h0;
  logic [1:0][`RAM_ADDR_W-1:0] location = '0;
  logic [1:0][`RAM_DATA_W-1:0] write_data = '0;
  logic [1:0] ready;
  logic [1:0][`RAM_DATA_W-1:0] read_data;
  logic [1:0] read_valid;
  logic [`RAM_DATA_W-1:0] rd;
  logic [`RAM_DATA_W-1:0] exp_w;
  logic [2:0] idle_b;
  int miscompares = 0;
  int total_checks = 0;
  // Full width, upper location bits must be masked off by the user end
  row_t rows [6] = '{
    '{1'b0, 1'b1, 12'h005, 9'h1A5, 9'h000},
    '{1'b1, 1'b1, 12'h1FF, 9'h0C3, 9'h000},
    '{1'b1, 1'b0, 12'h005, 9'h000, 9'h1A5},
    '{1'b0, 1'b0, 12'h1FF, 9'h000, 9'h0C3},
    '{1'b0, 1'b1, 12'hE07, 9'h155, 9'h000},
    '{1'b1, 1'b0, 12'h007, 9'h000, 9'h155}};

  always #20 clock = ~clock;

  ram_link_if ram_link_if_inst ();
  dual_port_ram_core dual_port_ram_core_inst (.clock(clock),
    .sys_rst(sys_rst), .link(ram_link_if_inst.ram_end));
  dual_port_ram_user #(.DIV(4)) dual_port_ram_user_inst (.clock(clock),
    .sys_rst(sys_rst), .width_cfg(width_cfg), .port_enable(port_enable),
    .registered_read(registered_read),
    .write_passthrough(write_passthrough), .ram_reset_req(ram_reset_req),
    .req(req), .write(write), .location(location),
    .write_data(write_data), .ready(ready), .read_data(read_data),
    .read_valid(read_valid), .link(ram_link_if_inst.user_end));
  dual_port_block_ram_ports_props dual_port_block_ram_ports_props_inst (
    .clock(clock), .sys_rst(sys_rst),
    .ram_reset_n(ram_link_if_inst.ram_reset_n),
    .port_a_clock(ram_link_if_inst.port_a_clock),
    .port_a_select_n(ram_link_if_inst.port_a_select_n),
    .port_a_write_n(ram_link_if_inst.port_a_write_n),
    .port_a_registered_read(ram_link_if_inst.port_a_registered_read),
    .port_a_write_passthrough(ram_link_if_inst.port_a_write_passthrough),
    .port_a_width_select(ram_link_if_inst.port_a_width_select),
    .port_a_location(ram_link_if_inst.port_a_location),
    .port_a_write_data(ram_link_if_inst.port_a_write_data),
    .port_a_read_data(ram_link_if_inst.port_a_read_data),
    .port_b_clock(ram_link_if_inst.port_b_clock),
    .port_b_select_n(ram_link_if_inst.port_b_select_n),
    .port_b_width_select(ram_link_if_inst.port_b_width_select),
    .port_b_read_data(ram_link_if_inst.port_b_read_data));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic do_reset(input logic [1:0] w, input logic [1:0] en);
    @(posedge clock);
    sys_rst <= 1'b1;
    width_cfg <= w;
    port_enable <= en;
    repeat (7) @(posedge clock);
    // Looked at mid-cycle, clear of the edge that launches it
    @(negedge clock);
    `CHK("reset_out", 9'h000, ram_link_if_inst.port_a_read_data)
    `CHK("reset_ready", en, ready)
    `CHK("reset_valid", 2'h0, read_valid)
    @(posedge clock);
    sys_rst <= 1'b0;
  endtask : do_reset

  // Waits for ready on writes and read_valid on reads, bounded
  task automatic do_op(input int p, input logic wr,
      input logic [`RAM_ADDR_W-1:0] loc, input logic [`RAM_DATA_W-1:0] wd,
      output logic [`RAM_DATA_W-1:0] rv);
    int n;
    n = 0;
    @(posedge clock);
    req[p] <= 1'b1;
    write[p] <= wr;
    location[p] <= loc;
    write_data[p] <= wd;
    @(posedge clock);
    req[p] <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (!(wr ? ready[p] === 1'b1 : read_valid[p] === 1'b1) && n < 40);
    `CHK("handshake", 1'b1, n < 40)
    rv = read_data[p];
  endtask : do_op

  initial begin
    #(40 * 20000);
    miscompares++;
    end_of_test();
  end

  initial begin
    do_reset(2'h3, 2'h3);
    foreach (rows[i]) begin
      do_op(rows[i].p, rows[i].wr, rows[i].loc, rows[i].wd, rd);
      if (!rows[i].wr) `CHK("row_read", rows[i].exp, rd)
    end
    do_op(0, 1'b0, 12'h005, 9'h000, rd);
    do_op(0, 1'b1, 12'h009, 9'h111, rd);
    @(negedge clock);
    `CHK("hold_write", 9'h1A5, ram_link_if_inst.port_a_read_data)
    @(posedge clock);
    write_passthrough <= 2'h3;
    do_op(0, 1'b1, 12'h009, 9'h122, rd);
    @(negedge clock);
    `CHK("pass_write", 9'h122, ram_link_if_inst.port_a_read_data)
    do_op(0, 1'b0, 12'h005, 9'h000, rd);
    `CHK("pass_read", 9'h1A5, rd)
    @(posedge clock);
    write_passthrough <= 2'h0;
    registered_read <= 2'h1;
    do_op(0, 1'b0, 12'h1FF, 9'h000, rd);
    do_op(0, 1'b0, 12'h005, 9'h000, rd);
    `CHK("reg_read1", 9'h0C3, rd)
    do_op(0, 1'b0, 12'h009, 9'h000, rd);
    `CHK("reg_read2", 9'h1A5, rd)
    @(posedge clock);
    registered_read <= 2'h0;
    ram_reset_req <= 1'b1;
    repeat (12) @(negedge clock);
    `CHK("mem_rst", 1'b0, ram_link_if_inst.ram_reset_n)
    `CHK("mem_rst_b", 9'h000, ram_link_if_inst.port_b_read_data)
    @(posedge clock);
    ram_reset_req <= 1'b0;
    do_op(1, 1'b0, 12'h009, 9'h000, rd);
    `CHK("kept", 9'h122, rd)
    // Two neighbouring locations: the read must see only its own lanes
    for (int w = 0; w < 3; w++) begin
      do_reset(w[1:0], 2'h3);
      exp_w = (w == 0) ? 9'h001 : (w == 1) ? 9'h003 : 9'h00F;
      do_op(0, 1'b1, 12'h009, 9'h1FF, rd);
      do_op(0, 1'b1, 12'h008, 9'h000, rd);
      do_op(1, 1'b0, 12'h009, 9'h000, rd);
      `CHK("width", exp_w, rd)
    end
    // Port B switched off in reset: its lines stay low, port A still works
    do_reset(2'h0, 2'h1);
    repeat (4) begin
      @(negedge clock);
      idle_b = {ready[1], ram_link_if_inst.port_b_clock,
                ram_link_if_inst.port_b_select_n};
      `CHK("port_b_off", 3'h0, idle_b)
    end
    do_op(0, 1'b0, 12'h009, 9'h000, rd);
    `CHK("single_port", 9'h001, rd)
    end_of_test();
  end
endmodule : dual_port_block_ram_ports_test

`default_nettype wire
